/* common/bbx_pkg.sv */
// Purpose: shared constants and types for the branch and bit-set executor
// Assumes: one pclk, four phases per instruction cycle
// Notes: data memory is read combinationally and written on the pclk edge by the core fabric
// How it works
// - branch_not_zero_op is e1nn; branches only on zero clear, no flags touched
// - taken conditional branch is two cycles; not taken is one, PC only steps by 2
// - branch_no_overflow_op loads target on overflow clear, else falls to address+2
// - target is incremented PC plus twice the signed offset
// - branch_always_op is 11010 plus 11-bit signed offset, always taken, no flags
// - branch_always_op writes PC in phase four, then one idle cycle
// - bit_set_file_op 1000 bbba ffff ffff sets one bit in one cycle
// - access flag zero uses access bank, one uses bank_select_reg
// - extended set, access flag zero, address up to 5f uses indexed offset
package bbx_pkg;
	localparam int PC_W = 16;
	localparam int DA_W = 12;
	localparam logic [7:0] OP_BR_NZ = 8'he1;
	localparam logic [7:0] OP_BR_NOV = 8'he5;
	localparam logic [4:0] OP_BR_AL = 5'h1a;
	localparam logic [3:0] OP_BIT_SET = 4'h8;
	localparam logic [15:0] NOP_WORD = 16'h0000;
	localparam logic [PC_W-1:0] RESET_VEC = 16'h0000;
	localparam logic [PC_W-1:0] PC_STEP = 16'h0002;
	localparam logic [7:0] IDX_LIMIT = 8'h5f;
	localparam logic [3:0] ACC_HI_BANK = 4'hf;
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] STAT_OFF = 12'h004;
	localparam int CTRL_EXT_BIT = 0;
	localparam int CTRL_BANK_LSB = 8;
	localparam int STAT_FLUSH_BIT = 16;
	localparam int STAT_Q_LSB = 17;
	typedef enum logic [1:0] {
		BBX_Q1 = 2'b00,
		BBX_Q2 = 2'b01,
		BBX_Q3 = 2'b10,
		BBX_Q4 = 2'b11
	} bbx_phase_t;
	typedef struct packed {
		logic [DA_W-1:0] addr;
		logic [7:0] wdata;
		logic re;
		logic we;
	} bbx_dreq_t;
	typedef struct packed {
		bbx_phase_t q;
		logic [PC_W-1:0] pc;
		logic [15:0] ir;
		logic flush;
		logic taken;
		logic [7:0] rd;
		bbx_dreq_t dreq;
		logic ext_en;
		logic [3:0] bank_sel;
		logic [31:0] prdata;
	} bbx_state_t;
endpackage

/* hdl/bbx_exec.sv */
// Purpose: executes the relative branches and the bit-set instruction
// Assumes: flags and memories sit on pclk; no synchroniser needed for them
// Notes: other opcodes pass through as one-cycle no-ops
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module bbx_exec
(
	input wire logic pclk, // core clock
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	output logic [bbx_pkg::PC_W-1:0] pmem_addr, // fetch address
	input wire logic [15:0] pmem_rdata, // fetched word
	output bbx_pkg::bbx_dreq_t dmem_req, // data memory request
	input wire logic [7:0] dmem_rdata, // data memory read value
	input wire logic zero_flag, // core zero flag
	input wire logic ovf_flag, // core overflow flag
	input wire logic [bbx_pkg::DA_W-1:0] index_base, // indexed offset base
	output logic [1:0] phase // current phase
);
	bbx_pkg::bbx_state_t st_ff;
	bbx_pkg::bbx_state_t nxt_st;
	logic live;
	logic is_br_nz;
	logic is_br_nov;
	logic is_br_al;
	logic is_bit_set;
	logic [bbx_pkg::PC_W-1:0] target;
	logic [7:0] bit_mask;
	logic [bbx_pkg::DA_W-1:0] bit_addr;
	logic apb_wr;
	logic apb_setup;
	logic hit_ctrl;
	logic hit_stat;

	assign live = !st_ff.flush;
	assign is_br_nz = st_ff.ir[15:8] == bbx_pkg::OP_BR_NZ;
	assign is_br_nov = st_ff.ir[15:8] == bbx_pkg::OP_BR_NOV;
	assign is_br_al = st_ff.ir[15:11] == bbx_pkg::OP_BR_AL;
	assign is_bit_set = st_ff.ir[15:12] == bbx_pkg::OP_BIT_SET;
	assign bit_mask = 8'h01 << st_ff.ir[11:9];

	// pc already points past this word, so target is address+2+2n
	always_comb
	begin
		if (is_br_al)
			target = st_ff.pc + {{(bbx_pkg::PC_W-12){st_ff.ir[10]}}, st_ff.ir[10:0], 1'b0};
		else
			target = st_ff.pc + {{(bbx_pkg::PC_W-9){st_ff.ir[7]}}, st_ff.ir[7:0], 1'b0};
	end

	always_comb
	begin
		if (st_ff.ir[8])
			bit_addr = {st_ff.bank_sel, st_ff.ir[7:0]};
		else if (st_ff.ext_en && st_ff.ir[7:0] <= bbx_pkg::IDX_LIMIT)
			bit_addr = index_base + {4'h0, st_ff.ir[7:0]};
		else if (st_ff.ir[7:0] <= bbx_pkg::IDX_LIMIT)
			bit_addr = {4'h0, st_ff.ir[7:0]};
		else
			bit_addr = {bbx_pkg::ACC_HI_BANK, st_ff.ir[7:0]};
	end

	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite;
	assign hit_ctrl = paddr == bbx_pkg::CTRL_OFF;
	assign hit_stat = paddr == bbx_pkg::STAT_OFF;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.dreq.re = 1'b0;
		nxt_st.dreq.we = 1'b0;
		case (st_ff.q)
			bbx_pkg::BBX_Q1:
			begin
				nxt_st.q = bbx_pkg::BBX_Q2;
				nxt_st.taken = 1'b0;
				if (live && is_bit_set)
				begin
					nxt_st.dreq.re = 1'b1;
					nxt_st.dreq.addr = bit_addr;
				end
			end
			bbx_pkg::BBX_Q2:
			begin
				nxt_st.q = bbx_pkg::BBX_Q3;
				if (st_ff.dreq.re)
					nxt_st.rd = dmem_rdata;
			end
			bbx_pkg::BBX_Q3:
			begin
				nxt_st.q = bbx_pkg::BBX_Q4;
				// flags only read here; nothing in this block writes them
				if (live && is_br_nz)
					nxt_st.taken = !zero_flag;
				else if (live && is_br_nov)
					nxt_st.taken = !ovf_flag;
				else if (live && is_br_al)
					nxt_st.taken = 1'b1;
				if (live && is_bit_set)
				begin
					nxt_st.dreq.we = 1'b1;
					nxt_st.dreq.wdata = st_ff.rd | bit_mask;
				end
			end
			bbx_pkg::BBX_Q4:
			begin
				nxt_st.q = bbx_pkg::BBX_Q1;
				if (st_ff.taken)
				begin
					nxt_st.pc = target;
					nxt_st.ir = bbx_pkg::NOP_WORD;
					nxt_st.flush = 1'b1;
				end
				else
				begin
					nxt_st.pc = st_ff.pc + bbx_pkg::PC_STEP;
					nxt_st.ir = pmem_rdata;
					nxt_st.flush = 1'b0;
				end
			end
			default:
				nxt_st.q = bbx_pkg::BBX_Q1;
		endcase
		// read data captured in setup so the access phase needs no wait
		if (apb_setup)
		begin
			nxt_st.prdata = 32'h0000_0000;
			if (hit_ctrl)
			begin
				nxt_st.prdata[bbx_pkg::CTRL_EXT_BIT] = st_ff.ext_en;
				nxt_st.prdata[bbx_pkg::CTRL_BANK_LSB +: 4] = st_ff.bank_sel;
			end
			else if (hit_stat)
			begin
				nxt_st.prdata[bbx_pkg::PC_W-1:0] = st_ff.pc;
				nxt_st.prdata[bbx_pkg::STAT_FLUSH_BIT] = st_ff.flush;
				nxt_st.prdata[bbx_pkg::STAT_Q_LSB +: 2] = st_ff.q;
			end
		end
		if (apb_wr && hit_ctrl)
		begin
			nxt_st.ext_en = pwdata[bbx_pkg::CTRL_EXT_BIT];
			nxt_st.bank_sel = pwdata[bbx_pkg::CTRL_BANK_LSB +: 4];
		end
	end

	// reset starts with a flush so the first cycle fetches the reset vector
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_ff <= '0;
			st_ff.pc <= bbx_pkg::RESET_VEC;
			st_ff.ir <= bbx_pkg::NOP_WORD;
			st_ff.flush <= 1'b1;
			st_ff.q <= bbx_pkg::BBX_Q1;
		end
		else
			st_ff <= nxt_st;
	end

	assign prdata = st_ff.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_ctrl && !hit_stat;
	assign pmem_addr = st_ff.pc;
	assign dmem_req = st_ff.dreq;
	assign phase = st_ff.q;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	nz_cond_a: assert property ((st_ff.q == bbx_pkg::BBX_Q3 && live && is_br_nz)
		|=> st_ff.taken == !$past(zero_flag))
		else $error("branch on not zero decided wrongly");
	nov_cond_a: assert property ((st_ff.q == bbx_pkg::BBX_Q3 && live && is_br_nov)
		|=> st_ff.taken == !$past(ovf_flag))
		else $error("branch on no overflow decided wrongly");
	br_always_a: assert property ((st_ff.q == bbx_pkg::BBX_Q3 && live && is_br_al)
		|=> st_ff.taken ##1 st_ff.pc == $past(target))
		else $error("unconditional branch not taken");
	target_load_a: assert property ((st_ff.q == bbx_pkg::BBX_Q4 && st_ff.taken)
		|=> st_ff.pc == $past(target) && st_ff.q == bbx_pkg::BBX_Q1)
		else $error("branch target not loaded in phase four");
	idle_cycle_a: assert property ((st_ff.q == bbx_pkg::BBX_Q4 && st_ff.taken)
		|=> (st_ff.flush && !st_ff.dreq.we && !st_ff.dreq.re) [*4] ##1 !st_ff.taken)
		else $error("taken branch lacks its idle cycle");
	not_taken_a: assert property ((st_ff.q == bbx_pkg::BBX_Q4 && !st_ff.taken)
		|=> st_ff.pc == $past(st_ff.pc) + bbx_pkg::PC_STEP && !st_ff.flush)
		else $error("fall-through did not step the fetch address");
	prefetch_drop_a: assert property ((st_ff.q == bbx_pkg::BBX_Q4 && st_ff.taken)
		|=> st_ff.ir == bbx_pkg::NOP_WORD)
		else $error("prefetched word not discarded");
	bit_set_a: assert property ((st_ff.q == bbx_pkg::BBX_Q2 && st_ff.dreq.re && live)
		|=> ##1 st_ff.dreq.we && st_ff.dreq.wdata == ($past(dmem_rdata, 2) | bit_mask))
		else $error("bit set wrote a wrong value");
	bank_sel_a: assert property ((st_ff.q == bbx_pkg::BBX_Q1 && live && is_bit_set
		&& st_ff.ir[8]) |=> st_ff.dreq.addr == {$past(st_ff.bank_sel), st_ff.ir[7:0]})
		else $error("banked address not from bank select");
	indexed_a: assert property ((st_ff.q == bbx_pkg::BBX_Q1 && live && is_bit_set
		&& !st_ff.ir[8] && st_ff.ext_en && st_ff.ir[7:0] <= bbx_pkg::IDX_LIMIT)
		|=> st_ff.dreq.addr == $past(index_base) + {4'h0, st_ff.ir[7:0]})
		else $error("indexed literal offset address wrong");
endmodule

/* verif/bbx_mem_model.sv */
// Purpose: program and data memory on the far side of the executor
// Assumes: both memories answer combinationally within the pclk cycle
// Notes: an unread data bus shows the inverse of the last read, not a held value
`timescale 1ns/1ps
module bbx_mem_model
(
	input wire logic pclk, // core clock
	input wire logic [15:0] pmem_addr, // fetch byte address
	output logic [15:0] pmem_rdata, // fetched word
	input wire bbx_pkg::bbx_dreq_t dmem_req, // data request
	output logic [7:0] dmem_rdata // data read value
);
	logic [15:0] pmem [32768];
	logic [7:0] dmem [4096];
	logic [7:0] last_ff;
	initial
	begin
		foreach (pmem[i]) pmem[i] = 16'h0000;
		foreach (dmem[i]) dmem[i] = 8'h00;
		last_ff = 8'h00;
	end
	assign pmem_rdata = pmem[pmem_addr[15:1]];
	assign dmem_rdata = dmem_req.re ? dmem[dmem_req.addr] : ~last_ff;
	always @(posedge pclk)
	begin
		if (dmem_req.re)
			last_ff <= dmem[dmem_req.addr];
		if (dmem_req.we)
			dmem[dmem_req.addr] <= dmem_req.wdata;
	end
endmodule

/* verif/testbench.sv */
// Purpose: self-checking bench for the branch and bit-set executor
// Assumes: one program in the memory model, run once from reset
// Notes: step lands on phase one of the next cycle and checks the fetch address
`timescale 1ns/1ps
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic zero_flag = 1'b0;
	logic ovf_flag = 1'b0;
	logic [11:0] index_base = 12'h100;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err;
	logic [15:0] pmem_addr, pmem_rdata;
	logic [7:0] dmem_rdata;
	logic [1:0] phase;
	bbx_pkg::bbx_dreq_t dmem_req;
	int fail_count = 0;
	int samples_checked = 0;
	always #50 pclk = ~pclk;
	bbx_exec dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .pmem_addr, .pmem_rdata, .dmem_req, .dmem_rdata, .zero_flag,
		.ovf_flag, .index_base, .phase);
	bbx_mem_model mem_u (.pclk, .pmem_addr, .pmem_rdata, .dmem_req, .dmem_rdata);
	task check(input logic [31:0] seen, input logic [31:0] exp);
	begin
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	task report_and_stop;
	begin
		$display("checks=%0d errors=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
	begin
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask
	// flags go out on the edge that opens phase one, so they are settled by phase three
	task step(input logic z, input logic o, input logic [15:0] exp);
	begin
		while (phase !== 2'd3)
			@(posedge pclk);
		zero_flag <= z;
		ovf_flag <= o;
		#1;
		check({16'h0, pmem_addr}, {16'h0, exp});
	end
	endtask
	task branch_cond;
	begin
		step(1'b0, 1'b1, 16'h0002);
		step(1'b0, 1'b0, 16'h0006);
		step(1'b1, 1'b0, 16'h0008);
		step(1'b1, 1'b0, 16'h000a);
		step(1'b0, 1'b0, 16'h000c);
		step(1'b0, 1'b1, 16'h000e);
		step(1'b1, 1'b1, 16'h0010);
	end
	endtask
	task branch_always;
	begin
		step(1'b0, 1'b0, 16'h0020);
		step(1'b0, 1'b0, 16'h0022);
		step(1'b0, 1'b0, 16'hf822);
	end
	endtask
	task bit_set;
	begin
		step(1'b0, 1'b0, 16'hf824);
		apb(1'b1, 12'h000, 32'h0000_0300);
		step(1'b0, 1'b0, 16'hf826);
		step(1'b0, 1'b0, 16'hf828);
		step(1'b0, 1'b0, 16'hf82a);
		step(1'b0, 1'b0, 16'hf82c);
		apb(1'b1, 12'h000, 32'h0000_0301);
		step(1'b0, 1'b0, 16'hf82e);
		step(1'b0, 1'b0, 16'hf830);
		check({24'h0, mem_u.dmem[12'h312]}, 32'h8a);
		check({24'h0, mem_u.dmem[12'hf80]}, 32'h01);
		check({24'h0, mem_u.dmem[12'h020]}, 32'h02);
		check({24'h0, mem_u.dmem[12'h120]}, 32'h14);
	end
	endtask
	task reg_access;
	begin
		apb(1'b1, 12'h008, 32'hffff_ffff);
		apb(1'b0, 12'h000, 32'h0);
		check(rd, 32'h0000_0301);
		apb(1'b0, 12'h008, 32'h0);
		check({rd[30:0], err}, 32'h1);
		// setup lands in phase three of the nop cycle with fetch address f834
		apb(1'b0, 12'h004, 32'h0);
		check(rd, 32'h0004_f834);
		check({31'h0, err}, 32'h0);
	end
	endtask
	initial
	begin
		@(posedge pclk);
		mem_u.pmem[0] = 16'he102;
		mem_u.pmem[3] = 16'he17f;
		mem_u.pmem[4] = 16'he501;
		mem_u.pmem[6] = 16'he500;
		mem_u.pmem[7] = 16'hd008;
		mem_u.pmem[16] = 16'hd400;
		mem_u.pmem[16'h7c12] = 16'h8f12;
		mem_u.pmem[16'h7c13] = 16'h8080;
		mem_u.pmem[16'h7c14] = 16'h8220;
		mem_u.pmem[16'h7c16] = 16'h8420;
		mem_u.dmem[12'h312] = 8'h0a;
		mem_u.dmem[12'h120] = 8'h10;
		@(posedge pclk);
		presetn <= 1'b1;
		branch_cond();
		branch_always();
		bit_set();
		reg_access();
		report_and_stop();
	end
	initial
	begin
		#20000;
		fail_count++;
		report_and_stop();
	end
endmodule
